/* test/bridge_driver_model.sv */
// Switch driver inputs on the four pins, with pull-downs
`timescale 1ns/1ns
`default_nettype none
module bridge_driver_model (
    input  wire logic [3:0] pin_i,
    input  wire logic [3:0] oe_n_i,
    output var logic  [3:0] pad_o
);
    // Released pin falls to the pull-down, keeping its switch off
    assign pad_o = pin_i & ~oe_n_i;
endmodule // bridge_driver_model
`default_nettype wire

/* test/pwm_chk_assertions.sv */
// Checker for the PWM shutdown, dead-band and steering block
`timescale 1ns/1ns
`default_nettype none
`include "pwm_steer_defines.vh"
module pwm_chk (
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        pwm_raw_i,
    input wire logic        comparator_one_out_i,
    input wire logic        comparator_two_out_i,
    input wire logic        external_interrupt_pin_i,
    input wire logic        pwm_out_a_o,
    input wire logic        pwm_out_c_o,
    input wire logic        pwm_out_a_oe_n_o,
    input wire logic        pwm_out_b_oe_n_o,
    input wire logic        pwm_out_c_oe_n_o
);
    logic [7:0] sh_r, un_r;
    logic [3:0] st_r, dr_r;
    logic [1:0] age_r;
    wire logic  wr = psel_i && penable_i && pready_o && pwrite_i;
    wire logic  src = (sh_r[4] && comparator_one_out_i) || (sh_r[5] && comparator_two_out_i)
                      || (sh_r[6] && !external_interrupt_pin_i);
    wire logic  ok = age_r == 2'h3;
    wire logic  on = un_r[3:2] == 2'h3;
    wire logic  one = un_r[7:6] == 2'h0;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////
    // Shadow control registers and settle age since last write
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sh_r <= 8'h00;
            un_r <= 8'h00;
            st_r <= 4'h1;
            dr_r <= 4'hF;
            age_r <= 2'h0;
        end else begin
            if (wr && paddr_i == `ADDR_SHDN_CTRL) sh_r <= pwdata_i[7:0];
            if (wr && paddr_i == `ADDR_UNIT_CTRL) un_r <= pwdata_i[7:0];
            if (wr && paddr_i == `ADDR_STEER_CTRL) st_r <= pwdata_i[3:0];
            if (wr && paddr_i == `ADDR_PIN_DIR) dr_r <= pwdata_i[3:0];
            age_r <= wr ? 2'h0 : age_r + {1'h0, age_r != 2'h3};
        end
    end
    property p_ready_wait;
        $rose(penable_i) && psel_i |=> pready_o;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("no ready after one wait");
    property p_ready_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than a cycle");
    property p_err_map;
        pready_o && pslverr_o |-> !(paddr_i inside {`ADDR_ENH_CTRL, `ADDR_SHDN_CTRL,
            `ADDR_UNIT_CTRL, `ADDR_STEER_CTRL, `ADDR_PIN_DIR, `ADDR_PIN_STATE});
    endproperty
    a_err_map: assert property (p_err_map) else $error("error on mapped address");
    property p_dir_off;
        ok && dr_r[0] |-> pwm_out_a_oe_n_o;
    endproperty
    a_dir_off: assert property (p_dir_off) else $error("input pin driven");
    property p_shdn_low;
        ok && on && (!one || st_r[0]) && !dr_r[0] && sh_r[3:2] == 2'h0
            && $past(src) && $past(src, 2) |-> !pwm_out_a_o && !pwm_out_a_oe_n_o;
    endproperty
    a_shdn_low: assert property (p_shdn_low) else $error("pin a not low");
    property p_shdn_tri;
        ok && sh_r[1] && $past(src) && $past(src, 2) |-> pwm_out_b_oe_n_o;
    endproperty
    a_shdn_tri: assert property (p_shdn_tri) else $error("pin b not released");
    property p_steer_off;
        ok && on && one && !st_r[1] |-> pwm_out_b_oe_n_o;
    endproperty
    a_steer_off: assert property (p_steer_off) else $error("pin b steered");
    property p_steer_same;
        ok && on && one && st_r[0] && st_r[2] && !dr_r[0] && !dr_r[2]
            |-> pwm_out_a_o == pwm_out_c_o && pwm_out_a_oe_n_o == pwm_out_c_oe_n_o;
    endproperty
    a_steer_same: assert property (p_steer_same) else $error("a and c differ");
    property p_fall_now;
        ok && on && un_r[7:6] == 2'h2 && !un_r[1] && sh_r[3:2] == 2'h0 && $fell(pwm_raw_i)
            |-> ##[1:2] !pwm_out_a_o;
    endproperty
    a_fall_now: assert property (p_fall_now) else $error("falling edge delayed");
endmodule // pwm_chk
bind pwm_shutdown_deadband_steer pwm_chk u_chk (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pwm_raw_i(pwm_raw_i), .comparator_one_out_i(comparator_one_out_i),
    .comparator_two_out_i(comparator_two_out_i), .pwm_out_a_o(pwm_out_a_o),
    .external_interrupt_pin_i(external_interrupt_pin_i), .pwm_out_c_o(pwm_out_c_o),
    .pwm_out_a_oe_n_o(pwm_out_a_oe_n_o), .pwm_out_b_oe_n_o(pwm_out_b_oe_n_o),
    .pwm_out_c_oe_n_o(pwm_out_c_oe_n_o));
`default_nettype wire

/* test/testbench.sv */
// Self-checking testbench for the PWM shutdown, dead-band and steering block
`timescale 1ns/1ns
`default_nettype none
`include "pwm_steer_defines.vh"
module testbench;
    logic        ref_clk_i = 0, reset_n_i = 0, psel = 0, pen = 0, pwr = 0;
    logic        raw = 0, pstart = 0, c1 = 0, c2 = 0, ext = 1, raw_q = 0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0]  pin_q = 4'h0;
    wire  [31:0] rd;
    wire         rdy, err;
    wire  [3:0]  pin, oen, pad;
    typedef struct {logic [31:0] e; logic [31:0] m; logic r;} note_t;
    note_t       rq[$];
    int          da[$], db[$];
    int          n_mismatch = 0, checks_done = 0, ca = 0, cb = 0;
    pwm_shutdown_deadband_steer #(.CLK_PER_TCY(8'h01)) DUT (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wd), .prdata_o(rd), .pready_o(rdy),
        .pslverr_o(err), .pwm_raw_i(raw), .period_start_i(pstart),
        .comparator_one_out_i(c1), .comparator_two_out_i(c2), .external_interrupt_pin_i(ext),
        .pwm_out_a_o(pin[0]), .pwm_out_b_o(pin[1]), .pwm_out_c_o(pin[2]), .pwm_out_d_o(pin[3]),
        .pwm_out_a_oe_n_o(oen[0]), .pwm_out_b_oe_n_o(oen[1]), .pwm_out_c_oe_n_o(oen[2]),
        .pwm_out_d_oe_n_o(oen[3]));
    bridge_driver_model u_drv (.pin_i(pin), .oe_n_i(oen), .pad_o(pad));
    always #2 ref_clk_i = ~ref_clk_i;
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Bus transfer; notes the expected response before it starts
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m = 32'h0, input logic r = 1'b0);
        int i;
        i = 0;
        rq.push_back(note_t'{d, m, r});
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= d;
        @(posedge ref_clk_i);
        pen <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            i++;
        end while (rdy !== 1'b1 && i < 30);
        if (i >= 30) begin
            n_mismatch++;
            stop_test();
        end else begin
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    task automatic pulse();
        @(posedge ref_clk_i);
        pstart <= 1'b1;
        @(posedge ref_clk_i);
        pstart <= 1'b0;
    endtask
    // Monitor: responses and delayed rising pin edges take the oldest note
    always @(posedge ref_clk_i) begin
        note_t n;
        ca++;
        cb++;
        if (raw && !raw_q) ca = 0;
        if (!raw && raw_q) cb = 0;
        if (pin[0] && !pin_q[0] && da.size() > 0) chk("rise a", da[0] + 1, ca);
        if (pin[1] && !pin_q[1] && db.size() > 0) chk("rise b", db[0] + 1, cb);
        if (pin[0] && !pin_q[0] && da.size() > 0) void'(da.pop_front());
        if (pin[1] && !pin_q[1] && db.size() > 0) void'(db.pop_front());
        if (rdy === 1'b1 && rq.size() > 0) begin
            n = rq.pop_front();
            chk("read data", n.e & n.m, rd & n.m);
            chk("slave error", {31'h0, n.r}, {31'h0, err});
        end
        raw_q = raw;
        pin_q = pin;
    end
    ////////////////////////////////////////
    initial begin
        int d;
        int dl[4];
        void'($urandom(25));
        repeat (3) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        // Reset values, unmapped place, random readback
        apb(0, `ADDR_ENH_CTRL, 32'h00, 32'hFF);
        apb(0, `ADDR_SHDN_CTRL, 32'h00, 32'hFF);
        apb(0, `ADDR_UNIT_CTRL, 32'h00, 32'hFF);
        apb(0, `ADDR_STEER_CTRL, 32'h1, 32'hF);
        apb(0, `ADDR_PIN_DIR, 32'hF, 32'hF);
        apb(0, `ADDR_PIN_STATE, 32'h0F0, 32'h1FF);
        apb(1, 8'h18, 32'hFF, 32'h0, 1'b1);
        apb(0, 8'h18, 32'h0, 32'hFFFFFFFF, 1'b1);
        repeat (4) begin
            d = $urandom;
            apb(1, `ADDR_ENH_CTRL, d);
            apb(0, `ADDR_ENH_CTRL, d, 32'hFF);
        end
        apb(1, `ADDR_ENH_CTRL, 32'h00);
        // Steering over every pin combination, polarity, other mode
        apb(1, `ADDR_PIN_DIR, 32'h0);
        apb(1, `ADDR_UNIT_CTRL, 32'h0C);
        raw <= 1'b1;
        pulse();
        for (int s = 0; s < 16; s++) begin
            apb(1, `ADDR_STEER_CTRL, s);
            apb(0, `ADDR_PIN_STATE, 32'h200 | ((~s & 15) << 4) | s, 32'h3F0 | s);
        end
        apb(1, `ADDR_UNIT_CTRL, 32'h0F);
        apb(0, `ADDR_PIN_STATE, 32'h200, 32'h3FF);
        apb(1, `ADDR_UNIT_CTRL, 32'h4C);
        apb(0, `ADDR_PIN_STATE, 32'h2E1, 32'h3F1);
        apb(1, `ADDR_UNIT_CTRL, 32'h0C);
        // Level shutdown with restart by firmware
        apb(1, `ADDR_SHDN_CTRL, 32'h11);
        c1 <= 1'b1;
        apb(0, `ADDR_SHDN_CTRL, 32'h91, 32'hFF);
        apb(0, `ADDR_PIN_STATE, 32'h10A, 32'h3FF);
        apb(1, `ADDR_SHDN_CTRL, 32'h11);
        repeat (20) @(posedge ref_clk_i);
        apb(0, `ADDR_SHDN_CTRL, 32'h91, 32'hFF);
        c1 <= 1'b0;
        apb(0, `ADDR_PIN_STATE, 32'h00A, 32'h3FF);
        apb(1, `ADDR_SHDN_CTRL, 32'h11);
        apb(0, `ADDR_PIN_STATE, 32'h00A, 32'h3FF);
        pulse();
        apb(0, `ADDR_PIN_STATE, 32'h20F, 32'h3FF);
        apb(1, `ADDR_SHDN_CTRL, 32'h1A);
        c1 <= 1'b1;
        apb(0, `ADDR_PIN_STATE, 32'h1F0, 32'h3F0);
        chk("pads", 32'h0, {28'h0, pad});
        c1 <= 1'b0;
        apb(1, `ADDR_SHDN_CTRL, 32'h00);
        // Every source code against every source, auto restart on
        apb(1, `ADDR_ENH_CTRL, 32'h80);
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 3; k++) begin
                apb(1, `ADDR_SHDN_CTRL, c << 4);
                {ext, c2, c1} <= 3'h4 ^ (3'h1 << k);
                apb(0, `ADDR_SHDN_CTRL, (c << 4) | (c[k] << 7), 32'hFF);
                {ext, c2, c1} <= 3'h4;
                apb(0, `ADDR_SHDN_CTRL, c << 4, 32'hFF);
            end
        end
        // Software shutdown, with and without auto restart
        pulse();
        apb(1, `ADDR_SHDN_CTRL, 32'h80);
        apb(0, `ADDR_SHDN_CTRL, 32'h00, 32'hFF);
        apb(0, `ADDR_PIN_STATE, 32'h000, 32'h3FF);
        pulse();
        apb(0, `ADDR_PIN_STATE, 32'h20F, 32'h3FF);
        apb(1, `ADDR_ENH_CTRL, 32'h00);
        apb(1, `ADDR_SHDN_CTRL, 32'h80);
        apb(0, `ADDR_PIN_STATE, 32'h000, 32'h200);
        apb(1, `ADDR_SHDN_CTRL, 32'h00);
        // Dead-band on rising edges of both half-bridge outputs
        apb(1, `ADDR_UNIT_CTRL, 32'h8C);
        raw <= 1'b0;
        pulse();
        repeat (4) @(posedge ref_clk_i);
        dl = '{0, 1, 127, 0};
        dl[3] = $urandom_range(126, 2);
        foreach (dl[i]) begin
            apb(1, `ADDR_ENH_CTRL, dl[i]);
            da.push_back(dl[i]);
            raw <= 1'b1;
            repeat (dl[i] + 8) @(posedge ref_clk_i);
            db.push_back(dl[i]);
            raw <= 1'b0;
            repeat (dl[i] + 8) @(posedge ref_clk_i);
        end
        chk("edges left", 32'h0, da.size() + db.size());
        stop_test();
    end
endmodule // testbench
`default_nettype wire

/* verilog/pwm_shutdown_deadband_steer.v */
// PWM output stage: auto-shutdown, restart, dead-band and pulse steering
`timescale 1ns/1ns
`default_nettype none
`include "pwm_steer_defines.vh"

module pwm_shutdown_deadband_steer #(
    parameter [`TCY_DIV_W-1:0] CLK_PER_TCY = 8'h01  // Clock cycles per instruction cycle
) (
    input  wire        ref_clk_i,
    input  wire        reset_n_i,
    // APB slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // Timebase
    input  wire        pwm_raw_i,
    input  wire        period_start_i,
    // Shutdown sources
    input  wire        comparator_one_out_i,
    input  wire        comparator_two_out_i,
    input  wire        external_interrupt_pin_i,
    // Pins
    output reg         pwm_out_a_o,
    output reg         pwm_out_b_o,
    output reg         pwm_out_c_o,
    output reg         pwm_out_d_o,
    output reg         pwm_out_a_oe_n_o,
    output reg         pwm_out_b_oe_n_o,
    output reg         pwm_out_c_oe_n_o,
    output reg         pwm_out_d_oe_n_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and declarations
    reg  [7:0]          pwm_enhanced_control_r;
    reg                 shutdown_event_status_r;
    reg  [2:0]          shutdown_source_select_r;
    reg  [1:0]          pair_ac_shutdown_state_r;
    reg  [1:0]          pair_bd_shutdown_state_r;
    reg  [1:0]          output_config_select_r;
    reg  [3:0]          unit_mode_select_r;
    reg  [3:0]          steer_pin_enables_r;
    reg  [3:0]          pin_direction_r;
    reg                 run_r;
    reg  [`TCY_DIV_W-1:0] div_cnt_r;
    reg                 tcy_tick_r;
    reg  [3:0]          pin_val_nxt;
    reg  [3:0]          pin_oe_n_nxt;
    reg  [31:0]         rdata_nxt;
    reg                 addr_ok;

    wire                auto_restart_enable;
    wire [`DB_W-1:0]    dead_band_count;
    wire                shutdown_cond;
    wire                setup_ph;
    wire                wr_commit;
    wire                pwm_mode_on;
    wire                single_mode;
    wire                half_mode;
    wire [1:0]          db_in;
    wire [1:0]          db_out;

    assign auto_restart_enable = pwm_enhanced_control_r[`ENH_RESTART_BIT];
    assign dead_band_count     = pwm_enhanced_control_r[`ENH_DB_HI:`ENH_DB_LO];
    assign setup_ph  = psel_i & penable_i & ~pready_o;
    assign wr_commit = psel_i & penable_i & pready_o & pwrite_i;

    // Mode decode
    assign pwm_mode_on = (unit_mode_select_r[`MODE_PWM_HI:`MODE_PWM_LO] == `MODE_PWM_CODE);
    assign single_mode = pwm_mode_on & (output_config_select_r == `CFG_SINGLE);
    assign half_mode   = pwm_mode_on & (output_config_select_r == `CFG_HALF_BRIDGE);

    // Shutdown source decode, level sensitive
    assign shutdown_cond =
        (shutdown_source_select_r[`SRC_CMP1_BIT] & comparator_one_out_i) |
        (shutdown_source_select_r[`SRC_CMP2_BIT] & comparator_two_out_i) |
        (shutdown_source_select_r[`SRC_EXT_BIT]  & ~external_interrupt_pin_i);

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait state, commit at the pready edge
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end else begin
            pready_o  <= setup_ph;
            pslverr_o <= setup_ph & ~addr_ok;
            if (setup_ph && !pwrite_i) begin
                prdata_o <= rdata_nxt;
            end
        end
    end

    // Read mux and address decode
    always @* begin
        rdata_nxt = 32'h00000000;
        addr_ok   = 1'b1;
        if (paddr_i == `ADDR_ENH_CTRL) begin
            rdata_nxt[7:0] = pwm_enhanced_control_r;
        end else if (paddr_i == `ADDR_SHDN_CTRL) begin
            rdata_nxt[7:0] = {shutdown_event_status_r, shutdown_source_select_r,
                              pair_ac_shutdown_state_r, pair_bd_shutdown_state_r};
        end else if (paddr_i == `ADDR_UNIT_CTRL) begin
            rdata_nxt[7:0] = {output_config_select_r, 2'h0, unit_mode_select_r};
        end else if (paddr_i == `ADDR_STEER_CTRL) begin
            rdata_nxt[3:0] = steer_pin_enables_r;
        end else if (paddr_i == `ADDR_PIN_DIR) begin
            rdata_nxt[3:0] = pin_direction_r;
        end else if (paddr_i == `ADDR_PIN_STATE) begin
            rdata_nxt[9:0] = {run_r, shutdown_cond,
                              pwm_out_d_oe_n_o, pwm_out_c_oe_n_o,
                              pwm_out_b_oe_n_o, pwm_out_a_oe_n_o,
                              pwm_out_d_o, pwm_out_c_o, pwm_out_b_o, pwm_out_a_o};
        end else begin
            addr_ok = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwm_enhanced_control_r   <= `RST_ENH_CTRL;
            shutdown_source_select_r <= 3'h0;
            pair_ac_shutdown_state_r <= 2'h0;
            pair_bd_shutdown_state_r <= 2'h0;
            output_config_select_r   <= 2'h0;
            unit_mode_select_r       <= 4'h0;
            steer_pin_enables_r      <= `RST_STEER_CTRL;
            pin_direction_r          <= `RST_PIN_DIR;
        end else if (wr_commit) begin
            if (paddr_i == `ADDR_ENH_CTRL) begin
                pwm_enhanced_control_r <= pwdata_i[7:0];
            end else if (paddr_i == `ADDR_SHDN_CTRL) begin
                shutdown_source_select_r <= pwdata_i[`SHDN_SRC_HI:`SHDN_SRC_LO];
                pair_ac_shutdown_state_r <= pwdata_i[`SHDN_AC_HI:`SHDN_AC_LO];
                pair_bd_shutdown_state_r <= pwdata_i[`SHDN_BD_HI:`SHDN_BD_LO];
            end else if (paddr_i == `ADDR_UNIT_CTRL) begin
                output_config_select_r <= pwdata_i[`UNIT_CFG_HI:`UNIT_CFG_LO];
                unit_mode_select_r     <= pwdata_i[`UNIT_MODE_HI:`UNIT_MODE_LO];
            end else if (paddr_i == `ADDR_STEER_CTRL) begin
                steer_pin_enables_r <= pwdata_i[3:0];
            end else if (paddr_i == `ADDR_PIN_DIR) begin
                pin_direction_r <= pwdata_i[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shutdown event status; hardware set wins over any clear
    // A software set under auto-restart lives one cycle, enough to drop run
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shutdown_event_status_r <= 1'b0;
        end else if (shutdown_cond) begin
            shutdown_event_status_r <= 1'b1;
        end else if (wr_commit && paddr_i == `ADDR_SHDN_CTRL) begin
            shutdown_event_status_r <= pwdata_i[`SHDN_STATUS_BIT];
        end else if (auto_restart_enable) begin
            shutdown_event_status_r <= 1'b0;
        end
    end

    // Run gate: drops on shutdown, returns only at a period start
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_r <= 1'b0;
        end else if (shutdown_event_status_r || shutdown_cond) begin
            run_r <= 1'b0;
        end else if (period_start_i) begin
            run_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction cycle enable divider
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_cnt_r  <= {`TCY_DIV_W{1'b0}};
            tcy_tick_r <= 1'b0;
        end else if (div_cnt_r >= CLK_PER_TCY - 8'h01) begin
            div_cnt_r  <= {`TCY_DIV_W{1'b0}};
            tcy_tick_r <= 1'b1;
        end else begin
            div_cnt_r  <= div_cnt_r + 8'h01;
            tcy_tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Dead-band delay per half-bridge leg: A from pwm, B from its complement
    assign db_in = {~pwm_raw_i, pwm_raw_i};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_db
            reg              prev_r;
            reg [`DB_W-1:0]  cnt_r;
            wire             last_tick;
            always @(posedge ref_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    prev_r <= 1'b0;
                    cnt_r  <= {`DB_W{1'b0}};
                end else begin
                    prev_r <= db_in[g];
                    if (db_in[g] && !prev_r) begin
                        cnt_r <= dead_band_count;
                    end else if (!db_in[g]) begin
                        cnt_r <= {`DB_W{1'b0}};
                    end else if (tcy_tick_r && cnt_r != {`DB_W{1'b0}}) begin
                        cnt_r <= cnt_r - 7'h01;
                    end
                end
            end
            // Count is spent or spends its last unit this tick
            assign last_tick = (cnt_r[`DB_W-1:1] == {(`DB_W-1){1'b0}}) &
                               (~cnt_r[0] | tcy_tick_r);
            // Active once the count runs out; falling edge passes at once
            assign db_out[g] = db_in[g] & prev_r & last_tick |
                               db_in[g] & (dead_band_count == {`DB_W{1'b0}});
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Pin value and enable per pin: A=0, B=1, C=2, D=3
    always @* begin : pin_mux
        integer   i;
        reg       used;
        reg       act;
        reg       pol_lo;
        reg [1:0] sstate;
        pin_val_nxt  = 4'h0;
        pin_oe_n_nxt = 4'hF;
        used   = 1'b0;
        act    = 1'b0;
        pol_lo = 1'b0;
        sstate = 2'h0;
        for (i = 0; i < 4; i = i + 1) begin
            // A and C form one pair, B and D the other
            pol_lo = (i == 0 || i == 2) ? unit_mode_select_r[`MODE_POL_AC_BIT]
                                        : unit_mode_select_r[`MODE_POL_BD_BIT];
            sstate = (i == 0 || i == 2) ? pair_ac_shutdown_state_r
                                        : pair_bd_shutdown_state_r;
            if (single_mode) begin
                used = steer_pin_enables_r[i];
                act  = pwm_raw_i;
            end else if (half_mode) begin
                used = (i < 2);
                act  = db_out[i[0]];
            end else begin
                used = pwm_mode_on & (i == 0);
                act  = pwm_raw_i;
            end
            if (used && !pin_direction_r[i]) begin
                if (!run_r) begin
                    // Shutdown state for pins in use
                    pin_val_nxt[i]  = (sstate == `SSTATE_DRIVE_HI);
                    pin_oe_n_nxt[i] = sstate[`SSTATE_TRI_BIT];
                end else begin
                    pin_val_nxt[i]  = act ^ pol_lo;
                    pin_oe_n_nxt[i] = 1'b0;
                end
            end
        end
    end

    // Registered pin outputs
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwm_out_a_o      <= 1'b0;
            pwm_out_b_o      <= 1'b0;
            pwm_out_c_o      <= 1'b0;
            pwm_out_d_o      <= 1'b0;
            pwm_out_a_oe_n_o <= 1'b1;
            pwm_out_b_oe_n_o <= 1'b1;
            pwm_out_c_oe_n_o <= 1'b1;
            pwm_out_d_oe_n_o <= 1'b1;
        end else begin
            pwm_out_a_o      <= pin_val_nxt[0];
            pwm_out_b_o      <= pin_val_nxt[1];
            pwm_out_c_o      <= pin_val_nxt[2];
            pwm_out_d_o      <= pin_val_nxt[3];
            pwm_out_a_oe_n_o <= pin_oe_n_nxt[0];
            pwm_out_b_oe_n_o <= pin_oe_n_nxt[1];
            pwm_out_c_oe_n_o <= pin_oe_n_nxt[2];
            pwm_out_d_oe_n_o <= pin_oe_n_nxt[3];
        end
    end

endmodule // pwm_shutdown_deadband_steer

`default_nettype wire

/* verilog/pwm_steer_defines.vh */
// Constants for the PWM shutdown, dead-band and steering block
`ifndef PWM_STEER_DEFINES_VH
`define PWM_STEER_DEFINES_VH

// Register byte offsets
`define ADDR_ENH_CTRL      8'h00
`define ADDR_SHDN_CTRL     8'h04
`define ADDR_UNIT_CTRL     8'h08
`define ADDR_STEER_CTRL    8'h0C
`define ADDR_PIN_DIR       8'h10
`define ADDR_PIN_STATE     8'h14

// Reset values
`define RST_ENH_CTRL       8'h00
`define RST_SHDN_CTRL      8'h00
`define RST_UNIT_CTRL      8'h00
`define RST_STEER_CTRL     4'h1
`define RST_PIN_DIR        4'hF

// Enhanced control fields
`define ENH_RESTART_BIT    7
`define ENH_DB_HI          6
`define ENH_DB_LO          0

// Shutdown control fields
`define SHDN_STATUS_BIT    7
`define SHDN_SRC_HI        6
`define SHDN_SRC_LO        4
`define SHDN_AC_HI         3
`define SHDN_AC_LO         2
`define SHDN_BD_HI         1
`define SHDN_BD_LO         0
`define SRC_CMP1_BIT       0
`define SRC_CMP2_BIT       1
`define SRC_EXT_BIT        2

// Unit control fields: [7:6] output config, [3:0] unit mode
`define UNIT_CFG_HI        7
`define UNIT_CFG_LO        6
`define UNIT_MODE_HI       3
`define UNIT_MODE_LO       0
`define MODE_PWM_HI        3
`define MODE_PWM_LO        2
`define MODE_PWM_CODE      2'h3
`define MODE_POL_AC_BIT    1
`define MODE_POL_BD_BIT    0
`define CFG_SINGLE         2'h0
`define CFG_HALF_BRIDGE    2'h2

// Shutdown pin state codes
`define SSTATE_DRIVE_HI    2'h1
`define SSTATE_TRI_BIT     1

// Dead-band counter width and instruction cycle divider
`define DB_W               7
`define TCY_DIV_W          8

`endif
